//--- rtl/fault_flags_interrupt_unit.sv
`timescale 1ns/1ps
module fault_flags_interrupt_unit (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire fault_flags_pkg::reg_req_t i_reg,
  input wire fault_flags_pkg::fault_in_t i_faults,
  output logic [7:0] o_reg_rdata,
  output logic o_int_n,
  output fault_flags_pkg::config_out_t o_cfg
);
  import fault_flags_pkg::*;

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [1:0] temp_code(input fault_in_t f);
    if (f.temp_ge_150) begin
      return TEMP_150_UP;
    end else if (f.temp_ge_120) begin
      return TEMP_120_TO_150;
    end else if (f.temp_ge_85) begin
      return TEMP_85_TO_120;
    end
    return TEMP_BELOW_85;
  endfunction : temp_code

  function automatic logic irq_pending(input logic pg, input logic [PROT_FLAG_W-1:0] pf,
                                       input logic [7:0] m);
    return (pg & ~m[MASK_PG_BIT])
      | (pf[OVERVOLT_BIT] & ~m[MASK_OV_BIT])
      | (pf[SHORT_BIT] & ~m[MASK_SHORT_BIT])
      | pf[LOAD_READY_BIT] | pf[UNDERVOLT_BIT]
      | pf[TWARN_BIT] | pf[TSHUT_BIT];
  endfunction : irq_pending

  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_hit

  logic [PROT_FLAG_W-1:0] prot_set;
  logic [PROT_FLAG_W-1:0] prot_clr;
  logic pg_clr;
  logic srst_fire;

  always_comb begin
    nxt_st = st_ff;
    prot_set = '0;
    prot_set[LOAD_READY_BIT] = i_faults.load_result_ready;
    prot_set[UNDERVOLT_BIT] = i_faults.input_undervoltage;
    prot_set[TWARN_BIT] = i_faults.temp_ge_120;
    // only a fresh rising edge counts as a shutdown event
    prot_set[TSHUT_BIT] = i_faults.thermal_shutdown & ~st_ff.tshut_prev;
    prot_set[OVERVOLT_BIT] = i_faults.input_overvoltage;
    prot_set[SHORT_BIT] = i_faults.output_short;
    // a written zero clears, a written one leaves the flag alone
    prot_clr = '0;
    pg_clr = 1'b0;
    if (wr_hit(i_reg, ADDR_PROT)) begin
      prot_clr = ~i_reg.wdata[PROT_FLAG_W-1:0];
    end
    if (wr_hit(i_reg, ADDR_PG_TEMP)) begin
      pg_clr = ~i_reg.wdata[PG_BIT];
    end
    // set wins over a clear in the same cycle
    nxt_st.prot_flags = (st_ff.prot_flags & ~prot_clr) | prot_set;
    nxt_st.output_power_fault_flag = (st_ff.output_power_fault_flag & ~pg_clr)
      | i_faults.power_fault;
    nxt_st.tshut_prev = i_faults.thermal_shutdown;

    if (wr_hit(i_reg, ADDR_MASK)) begin
      nxt_st.mask = i_reg.wdata;
    end
    if (wr_hit(i_reg, ADDR_GEN)) begin
      nxt_st.gen = i_reg.wdata;
    end

    // software reset: write one then zero to the reset bit
    srst_fire = 1'b0;
    if (wr_hit(i_reg, ADDR_SWRST)) begin
      nxt_st.swrst_reg = i_reg.wdata;
      unique case (st_ff.srst)
        SRST_IDLE: begin
          if (i_reg.wdata[SWRST_BIT]) begin
            nxt_st.srst = SRST_ARMED;
          end
        end
        SRST_ARMED: begin
          if (!i_reg.wdata[SWRST_BIT]) begin
            srst_fire = 1'b1;
          end
        end
        default: begin
          nxt_st.srst = SRST_IDLE;
        end
      endcase
    end
    if (srst_fire) begin
      // flags are untouched here on purpose
      nxt_st.mask = MASK_RST;
      nxt_st.gen = GEN_RST;
      nxt_st.swrst_reg = SWRST_RST;
      nxt_st.srst = SRST_IDLE;
    end

    if (i_reg.rd) begin
      unique case (i_reg.addr)
        ADDR_PG_TEMP: begin
          nxt_st.rdata = {5'h00, st_ff.output_power_fault_flag, temp_code(i_faults)};
        end
        ADDR_PROT: begin
          nxt_st.rdata = {2'h0, st_ff.prot_flags};
        end
        ADDR_MASK: begin
          nxt_st.rdata = st_ff.mask;
        end
        ADDR_GEN: begin
          nxt_st.rdata = st_ff.gen;
        end
        ADDR_SWRST: begin
          nxt_st.rdata = st_ff.swrst_reg;
        end
        default: begin
          nxt_st.rdata = 8'h00;
        end
      endcase
    end

    nxt_st.int_n = ~irq_pending(nxt_st.output_power_fault_flag, nxt_st.prot_flags,
                                nxt_st.mask);
    nxt_st.cfg.spread_spectrum_en = nxt_st.gen[GEN_SS_BIT];
    nxt_st.cfg.feedback_amp_disable = nxt_st.gen[GEN_AMP_DIS_BIT];
    nxt_st.cfg.low_power_allow = nxt_st.gen[GEN_LP_BIT];
    // polarity one: pin active high; zero: active low
    nxt_st.cfg.sleep_active = nxt_st.gen[GEN_SLEEP_PIN_POLARITY_BIT] ? i_faults.sleep_pin
                                                          : ~i_faults.sleep_pin;
  end

  // async reset stands for a full power cycle and clears flags too
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff.output_power_fault_flag <= 1'b0;
      st_ff.prot_flags <= PROT_RST;
      st_ff.tshut_prev <= 1'b0;
      st_ff.mask <= MASK_RST;
      st_ff.gen <= GEN_RST;
      st_ff.swrst_reg <= SWRST_RST;
      st_ff.srst <= SRST_IDLE;
      st_ff.rdata <= RDATA_RST;
      st_ff.int_n <= 1'b1;
      st_ff.cfg.spread_spectrum_en <= GEN_RST[GEN_SS_BIT];
      st_ff.cfg.feedback_amp_disable <= GEN_RST[GEN_AMP_DIS_BIT];
      st_ff.cfg.low_power_allow <= GEN_RST[GEN_LP_BIT];
      st_ff.cfg.sleep_active <= 1'b0;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata = st_ff.rdata;
  assign o_int_n = st_ff.int_n;
  assign o_cfg = st_ff.cfg;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic prot_wr;
  assign prot_wr = i_clk_en && wr_hit(i_reg, ADDR_PROT);

  a_pg_flag_raise: assert property (
    i_clk_en && i_faults.power_fault |=> st_ff.output_power_fault_flag)
    else $error("power fault flag not raised");

  a_temp_readback: assert property (
    i_clk_en && i_reg.rd && i_reg.addr == ADDR_PG_TEMP
    |=> o_reg_rdata[1:0] == temp_code($past(i_faults)))
    else $error("temperature range read wrong");

  a_flag_sticky_pg: assert property (
    st_ff.output_power_fault_flag && !(i_clk_en && wr_hit(i_reg, ADDR_PG_TEMP)
      && !i_reg.wdata[PG_BIT]) |=> st_ff.output_power_fault_flag)
    else $error("power fault flag lost without clear");

  a_read_keeps_flags: assert property (
    i_reg.rd && !i_reg.wr
    |=> ($past(st_ff.prot_flags) & ~st_ff.prot_flags) == '0)
    else $error("read cleared a flag");

  a_ov_reraise: assert property (
    prot_wr && !i_reg.wdata[OVERVOLT_BIT] && i_faults.input_overvoltage
    |=> st_ff.prot_flags[OVERVOLT_BIT] && o_int_n == !irq_pending(
      st_ff.output_power_fault_flag, st_ff.prot_flags, st_ff.mask))
    else $error("overvoltage flag not re-raised");

  sequence tshut_cleared_while_hot;
    prot_wr && !i_reg.wdata[TSHUT_BIT] && i_faults.thermal_shutdown && st_ff.tshut_prev;
  endsequence

  a_tshut_stays_clear: assert property (
    tshut_cleared_while_hot |=> !st_ff.prot_flags[TSHUT_BIT])
    else $error("shutdown flag re-raised without new event");

  a_int_follows_flags: assert property (
    o_int_n == !irq_pending(st_ff.output_power_fault_flag, st_ff.prot_flags, st_ff.mask))
    else $error("interrupt pin disagrees with flags");

  a_event_flags_set: assert property (
    i_clk_en |=> (st_ff.prot_flags & {$past(i_faults.load_result_ready),
      $past(i_faults.input_undervoltage), $past(i_faults.temp_ge_120), 1'b1,
      $past(i_faults.input_overvoltage), $past(i_faults.output_short)})
      == {$past(i_faults.load_result_ready), $past(i_faults.input_undervoltage),
      $past(i_faults.temp_ge_120), st_ff.prot_flags[TSHUT_BIT],
      $past(i_faults.input_overvoltage), $past(i_faults.output_short)})
    else $error("event flag not set");

  a_tshut_edge_sets: assert property (
    i_clk_en && !i_faults.thermal_shutdown ##1 i_clk_en && i_faults.thermal_shutdown
    |=> st_ff.prot_flags[TSHUT_BIT] && !o_int_n)
    else $error("shutdown event not flagged");

  a_mask_blocks_pg: assert property (
    st_ff.mask[MASK_PG_BIT] && st_ff.prot_flags == '0 |-> o_int_n)
    else $error("masked power fault drove interrupt");

  a_cfg_outputs: assert property (
    o_cfg.spread_spectrum_en == st_ff.gen[GEN_SS_BIT]
    && o_cfg.feedback_amp_disable == st_ff.gen[GEN_AMP_DIS_BIT]
    && o_cfg.low_power_allow == st_ff.gen[GEN_LP_BIT])
    else $error("configuration outputs disagree with register");

  a_sleep_polarity: assert property (
    i_clk_en |=> o_cfg.sleep_active == (st_ff.gen[GEN_SLEEP_PIN_POLARITY_BIT] ?
      $past(i_faults.sleep_pin) : !$past(i_faults.sleep_pin)))
    else $error("sleep polarity wrong");

  sequence srst_armed_then_zero;
    st_ff.srst == SRST_ARMED && i_clk_en && wr_hit(i_reg, ADDR_SWRST)
      && !i_reg.wdata[SWRST_BIT];
  endsequence

  a_srst_keeps_flags: assert property (
    srst_armed_then_zero |=> st_ff.gen == GEN_RST && st_ff.mask == MASK_RST
      && ($past(st_ff.prot_flags) & ~st_ff.prot_flags) == '0)
    else $error("software reset wrong");

  // clock enable low holds every register, requests included
  a_clk_en_freeze: assert property (
    !i_clk_en |=> st_ff == $past(st_ff))
    else $error("state moved while clock enable low");

  sequence pg_cleared_idle;
    i_clk_en && wr_hit(i_reg, ADDR_PG_TEMP) && !i_reg.wdata[PG_BIT]
      && !i_faults.power_fault;
  endsequence

  a_pg_clear: assert property (
    pg_cleared_idle |=> !st_ff.output_power_fault_flag)
    else $error("power fault flag not cleared");

  sequence ov_cleared_idle;
    prot_wr && !i_reg.wdata[OVERVOLT_BIT] && !i_faults.input_overvoltage;
  endsequence

  a_ov_clear: assert property (
    ov_cleared_idle |=> !st_ff.prot_flags[OVERVOLT_BIT])
    else $error("overvoltage flag not cleared");

  sequence short_cleared_while_shorted;
    prot_wr && !i_reg.wdata[SHORT_BIT] && i_faults.output_short;
  endsequence

  a_short_reraise: assert property (
    short_cleared_while_shorted |=> st_ff.prot_flags[SHORT_BIT])
    else $error("short flag not re-raised");

  a_ones_keep_flags: assert property (
    prot_wr && i_reg.wdata[PROT_FLAG_W-1:0] == '1
    |=> ($past(st_ff.prot_flags) & ~st_ff.prot_flags) == '0)
    else $error("writing ones cleared a flag");

  a_pg_drives_int: assert property (
    st_ff.output_power_fault_flag && !st_ff.mask[MASK_PG_BIT] |-> !o_int_n)
    else $error("unmasked power fault left interrupt high");

  a_ov_drives_int: assert property (
    st_ff.prot_flags[OVERVOLT_BIT] && !st_ff.mask[MASK_OV_BIT] |-> !o_int_n)
    else $error("unmasked overvoltage left interrupt high");

  a_short_drives_int: assert property (
    st_ff.prot_flags[SHORT_BIT] && !st_ff.mask[MASK_SHORT_BIT] |-> !o_int_n)
    else $error("unmasked short left interrupt high");

  a_unmaskable_int: assert property (
    st_ff.prot_flags[LOAD_READY_BIT:TSHUT_BIT] != '0 |-> !o_int_n)
    else $error("unmaskable flag left interrupt high");

  a_quiet_int_high: assert property (
    !st_ff.output_power_fault_flag && st_ff.prot_flags == '0 |-> o_int_n)
    else $error("interrupt low with no flag set");

  a_mask_write: assert property (
    i_clk_en && wr_hit(i_reg, ADDR_MASK) |=> st_ff.mask == $past(i_reg.wdata))
    else $error("mask write lost");

  a_mask_readback: assert property (
    i_clk_en && i_reg.rd && i_reg.addr == ADDR_MASK |=> o_reg_rdata == $past(st_ff.mask))
    else $error("mask read wrong");

  a_gen_write: assert property (
    i_clk_en && wr_hit(i_reg, ADDR_GEN) |=> st_ff.gen == $past(i_reg.wdata))
    else $error("general register write lost");

  a_gen_readback: assert property (
    i_clk_en && i_reg.rd && i_reg.addr == ADDR_GEN |=> o_reg_rdata == $past(st_ff.gen))
    else $error("general register read wrong");

  sequence srst_one_written;
    i_clk_en && wr_hit(i_reg, ADDR_SWRST) && i_reg.wdata[SWRST_BIT];
  endsequence

  a_srst_arms: assert property (
    srst_one_written |=> st_ff.srst == SRST_ARMED)
    else $error("software reset not armed");

  a_srst_keeps_pg: assert property (
    srst_armed_then_zero
    |=> st_ff.output_power_fault_flag || !$past(st_ff.output_power_fault_flag))
    else $error("software reset cleared power fault flag");

endmodule : fault_flags_interrupt_unit

//--- rtl/fault_flags_pkg.sv
package fault_flags_pkg;

  // register addresses
  localparam logic [7:0] ADDR_PG_TEMP = 8'h0D;
  localparam logic [7:0] ADDR_PROT = 8'h0E;
  localparam logic [7:0] ADDR_MASK = 8'h0F;
  localparam logic [7:0] ADDR_GEN = 8'h10;
  localparam logic [7:0] ADDR_SWRST = 8'h11;

  // field positions
  localparam int PG_BIT = 2;
  localparam int LOAD_READY_BIT = 5;
  localparam int UNDERVOLT_BIT = 4;
  localparam int TWARN_BIT = 3;
  localparam int TSHUT_BIT = 2;
  localparam int OVERVOLT_BIT = 1;
  localparam int SHORT_BIT = 0;
  localparam int MASK_PG_BIT = 2;
  localparam int MASK_OV_BIT = 1;
  localparam int MASK_SHORT_BIT = 0;
  localparam int GEN_SS_BIT = 5;
  localparam int GEN_AMP_DIS_BIT = 3;
  localparam int GEN_SLEEP_PIN_POLARITY_BIT = 1;
  localparam int GEN_LP_BIT = 0;
  localparam int SWRST_BIT = 0;
  localparam int PROT_FLAG_W = 6;

  // reset values
  localparam logic [7:0] MASK_RST = 8'hF8;
  localparam logic [7:0] GEN_RST = 8'h01;
  localparam logic [7:0] SWRST_RST = 8'h00;
  localparam logic [PROT_FLAG_W-1:0] PROT_RST = 6'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // die temperature range codes
  localparam logic [1:0] TEMP_BELOW_85 = 2'h0;
  localparam logic [1:0] TEMP_85_TO_120 = 2'h1;
  localparam logic [1:0] TEMP_120_TO_150 = 2'h2;
  localparam logic [1:0] TEMP_150_UP = 2'h3;

  typedef enum logic [1:0] {
    SRST_IDLE = 2'b01,
    SRST_ARMED = 2'b10
  } srst_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_t;

  // comparator and detector levels from the analogue side
  typedef struct packed {
    logic power_fault;
    logic temp_ge_85;
    logic temp_ge_120;
    logic temp_ge_150;
    logic thermal_shutdown;
    logic input_undervoltage;
    logic input_overvoltage;
    logic output_short;
    logic load_result_ready;
    logic sleep_pin;
  } fault_in_t;

  typedef struct packed {
    logic spread_spectrum_en;
    logic feedback_amp_disable;
    logic low_power_allow;
    logic sleep_active;
  } config_out_t;

  typedef struct packed {
    logic output_power_fault_flag;
    logic [PROT_FLAG_W-1:0] prot_flags;
    logic tshut_prev;
    logic [7:0] mask;
    logic [7:0] gen;
    logic [7:0] swrst_reg;
    srst_state_t srst;
    logic [7:0] rdata;
    logic int_n;
    config_out_t cfg;
  } state_t;

endpackage : fault_flags_pkg

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  output fault_flags_pkg::reg_req_t o_reg
);
  import fault_flags_pkg::*;
  initial o_reg = '{addr: 8'hFF, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
  // one single-byte transfer, released address and data lines show the inverse of the last value, strobes drop to zero
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge i_core_clk);
    o_reg <= '{addr: a, wr: w, rd: ~w, wdata: d};
    @(posedge i_core_clk);
    o_reg <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    #1 q = i_rdata;
  endtask : access
endmodule : host_model

//--- tb/fault_flags_interrupt_unit_tb.sv
`timescale 1ns/1ps
module fault_flags_interrupt_unit_tb;
  import fault_flags_pkg::*;
  logic i_core_clk;
  logic i_rst_n;
  logic i_clk_en;
  reg_req_t i_reg;
  fault_in_t i_faults;
  logic [7:0] o_reg_rdata;
  logic o_int_n;
  config_out_t o_cfg;
  int err_count;
  int checked;
  int cycles;
  logic [7:0] q;

  fault_flags_interrupt_unit fault_flags_interrupt_unit_inst (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_reg(i_reg), .i_faults(i_faults),
    .o_reg_rdata(o_reg_rdata), .o_int_n(o_int_n), .o_cfg(o_cfg));
  host_model host_model_inst (.i_core_clk(i_core_clk), .i_rdata(o_reg_rdata), .o_reg(i_reg));

  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic stop_test;
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp, input string m);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %b exp %b", $time, m, got, exp);
    end
  endtask : chk1

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string m);
    host_model_inst.access(a, 1'b0, 8'h00, q);
    chk8(q, exp, m);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.access(a, 1'b1, d, q);
  endtask : wr

  task automatic set_fault(input logic [7:0] a, input int b, input logic v);
    @(posedge i_core_clk);
    if (a == ADDR_PG_TEMP) i_faults.power_fault <= v;
    else begin
      case (b)
        5: i_faults.load_result_ready <= v;
        4: i_faults.input_undervoltage <= v;
        3: i_faults.temp_ge_120 <= v;
        2: i_faults.thermal_shutdown <= v;
        1: i_faults.input_overvoltage <= v;
        default: i_faults.output_short <= v;
      endcase
    end
  endtask : set_fault

  task automatic t_reset;
    rd(ADDR_PG_TEMP, 8'h00, "flags0 rst");
    rd(ADDR_PROT, 8'h00, "flags1 rst");
    rd(ADDR_MASK, 8'hF8, "mask rst");
    rd(ADDR_GEN, 8'h01, "gen rst");
    rd(8'h20, 8'h00, "unmapped");
    chk1(o_int_n, 1'b1, "int rst");
    chk1(o_cfg.spread_spectrum_en, 1'b0, "ss rst");
    chk1(o_cfg.feedback_amp_disable, 1'b0, "amp rst");
    chk1(o_cfg.low_power_allow, 1'b1, "lp rst");
  endtask : t_reset

  task automatic t_temp;
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk);
      i_faults.temp_ge_85 <= (i >= 1);
      i_faults.temp_ge_120 <= (i >= 2);
      i_faults.temp_ge_150 <= (i >= 3);
      rd(ADDR_PG_TEMP, i[7:0], "temp code");
    end
    @(posedge i_core_clk);
    i_faults <= '0;
    wr(ADDR_PROT, 8'h00);
  endtask : t_temp

  task automatic flag_test(input logic [7:0] a, input int b, input logic rearm);
    set_fault(a, b, 1'b1);
    set_fault(a, b, 1'b0);
    rd(a, 8'h01 << b, "flag set");
    chk1(o_int_n, 1'b0, "int low");
    rd(a, 8'h01 << b, "after read");
    wr(a, 8'hFF);
    rd(a, 8'h01 << b, "write one");
    wr(a, 8'h00);
    rd(a, 8'h00, "cleared");
    chk1(o_int_n, 1'b1, "int high");
    set_fault(a, b, 1'b1);
    wr(a, 8'h00);
    rd(a, rearm ? 8'h01 << b : 8'h00, "persist");
    set_fault(a, b, 1'b0);
    wr(a, 8'h00);
  endtask : flag_test

  task automatic t_mask;
    logic [7:0] ta[3] = '{ADDR_PG_TEMP, ADDR_PROT, ADDR_PROT};
    int tb[3] = '{2, 1, 0};
    wr(ADDR_MASK, 8'hFF);
    rd(ADDR_MASK, 8'hFF, "mask rb");
    for (int i = 0; i < 3; i++) begin
      set_fault(ta[i], tb[i], 1'b1);
      set_fault(ta[i], tb[i], 1'b0);
      rd(ta[i], 8'h01 << tb[i], "masked flag");
      chk1(o_int_n, 1'b1, "masked int");
      wr(ADDR_MASK, 8'hF8);
      chk1(o_int_n, 1'b0, "unmasked int");
      wr(ta[i], 8'h00);
      wr(ADDR_MASK, 8'hFF);
    end
    wr(ADDR_MASK, 8'hF8);
  endtask : t_mask

  task automatic t_gen;
    @(posedge i_core_clk);
    i_faults.sleep_pin <= 1'b1;
    wr(ADDR_GEN, 8'h2A);
    @(posedge i_core_clk);
    #1;
    rd(ADDR_GEN, 8'h2A, "gen rb");
    chk1(o_cfg.spread_spectrum_en, 1'b1, "ss on");
    chk1(o_cfg.feedback_amp_disable, 1'b1, "amp off");
    chk1(o_cfg.low_power_allow, 1'b0, "lp off");
    chk1(o_cfg.sleep_active, 1'b1, "sleep high pol");
    wr(ADDR_GEN, 8'h28);
    @(posedge i_core_clk);
    #1;
    chk1(o_cfg.sleep_active, 1'b0, "sleep low pol");
    @(posedge i_core_clk);
    i_faults.sleep_pin <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    #1;
    chk1(o_cfg.sleep_active, 1'b1, "sleep low pol act");
  endtask : t_gen

  task automatic t_swrst;
    set_fault(ADDR_PROT, 0, 1'b1);
    set_fault(ADDR_PROT, 0, 1'b0);
    wr(ADDR_MASK, 8'h07);
    chk1(o_int_n, 1'b1, "masked");
    wr(ADDR_GEN, 8'h2A);
    wr(ADDR_SWRST, 8'h01);
    wr(ADDR_SWRST, 8'h00);
    rd(ADDR_MASK, 8'hF8, "mask swrst");
    rd(ADDR_GEN, 8'h01, "gen swrst");
    rd(ADDR_SWRST, 8'h00, "swrst reg");
    rd(ADDR_PROT, 8'h01, "flag kept");
    chk1(o_int_n, 1'b0, "int after swrst");
    wr(ADDR_PROT, 8'h00);
  endtask : t_swrst

  task automatic t_clk_en;
    @(posedge i_core_clk);
    i_clk_en <= 1'b0;
    i_faults.output_short <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_faults.output_short <= 1'b0;
    i_clk_en <= 1'b1;
    #1;
    chk1(o_int_n, 1'b1, "frozen int");
    rd(ADDR_PROT, 8'h00, "frozen flags");
  endtask : t_clk_en

  task automatic t_power_cycle;
    set_fault(ADDR_PG_TEMP, 2, 1'b1);
    set_fault(ADDR_PG_TEMP, 2, 1'b0);
    wr(ADDR_GEN, 8'h2A);
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_PG_TEMP, 8'h00, "flag after power cycle");
    rd(ADDR_GEN, 8'h01, "gen after power cycle");
    chk1(o_int_n, 1'b1, "int after power cycle");
    chk1(o_cfg.spread_spectrum_en, 1'b0, "ss after power cycle");
  endtask : t_power_cycle

  initial begin
    i_rst_n = 1'b0;
    i_clk_en = 1'b1;
    i_faults = '0;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_temp();
    flag_test(ADDR_PG_TEMP, 2, 1'b1);
    for (int b = 0; b < 6; b++) flag_test(ADDR_PROT, b, b != 2);
    t_mask();
    t_gen();
    t_swrst();
    t_clk_en();
    t_power_cycle();
    stop_test();
  end
endmodule : fault_flags_interrupt_unit_tb
